//--- hdl/ebi_bus_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - read strobe asserted on every external read, fetch or data
// - combined mode: low write strobe on every data write
// - split mode: low strobe for low-byte writes or any 8-bit bus write
// - config bit selects combined or split write-strobe mode
// - one pin gives high-byte enable or high-byte write strobe
// - ready active level programmable; ready function can be enabled
// - ready at inactive level stretches the access with wait states
// - external-fetch select must be low at and after reset
// - 16-bit demux address bus driven, also after switch to mux mode
// - segment address lines output on an 8-bit port, low to high
// - address latch enable output for latching multiplexed address
// - five chip-select outputs, zero to four
// - hold request in or out, plus hold acknowledge and bus request
// - system clock divided by two can be driven out on a pin
module ebi_bus_ctrl
   import ebi_pkg::*;
(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // register port
   input  wire logic [3:0]          regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output logic      [31:0]         regRdata,
   // core access request
   input  wire logic                reqValid,
   input  wire logic                reqWrite,
   input  wire logic                reqFetch,
   input  wire logic                reqByte,
   input  wire logic                reqHighByte,
   input  wire logic                reqBus8,
   input  wire logic [23:0]         reqAddr,
   input  wire logic [CS_IDX_W-1:0] reqCs,
   output logic                     reqDone,
   output logic                     reqBusy,
   // strap and ready
   input  wire logic                external_fetch_select,
   input  wire logic                readyPin,
   // strobes
   output logic                     rdStrobe_n,
   output logic                     low_byte_write_strobe_n,
   output logic                     high_byte_pin_n,
   output logic                     addrLatchEnable,
   // address and selects
   output logic      [ADDR_W-1:0]   demux_address_port,
   output logic      [SEG_W-1:0]    segAddr,
   output logic      [NUM_CS-1:0]   chipSelect_n,
   // arbitration
   input  wire logic                holdReqIn_n,
   output logic                     holdReqOut_n,
   output logic                     holdReqOutEn,
   output logic                     bus_hold_ack_n,
   output logic                     bus_request_out_n,
   // clock out
   output logic                     system_clock_out,
   // status
   output logic                     fetchExternal
);
   // ==========================================
   // registers
   logic [CFG_WIDTH-1:0] cfg_r;
   logic [SEG_W-1:0]     segShadow_r;
   logic [31:0]          regRdata_r;
   logic                 fetchExt_r;
   logic                 strapTaken_r;
   ebi_state_e           state_r;
   ebi_state_e           state_nxt;
   logic [1:0]           cnt_r;
   logic [1:0]           cnt_nxt;
   logic                 curWrite_r;
   logic                 curHigh_r;
   logic                 curByte_r;
   logic                 curBus8_r;
   logic [23:0]          curAddr_r;
   logic [CS_IDX_W-1:0]  curCs_r;
   logic                 rdN_r;
   logic                 wrLowN_r;
   logic                 hiPinN_r;
   logic                 ale_r;
   logic [ADDR_W-1:0]    addr_r;
   logic [SEG_W-1:0]     seg_r;
   logic [NUM_CS-1:0]    csN_r;
   logic                 holdAckN_r;
   logic                 busReqN_r;
   logic                 done_r;
   logic                 busyOut_r;
   logic                 holdOutN_r;
   logic                 holdOutEn_r;

   // ==========================================
   // register decode
   wire  write_strobe_config    = regWrite && (regAddr == REG_SYSCFG);
   wire  wrSeg    = regWrite && (regAddr == REG_SEGMENT);
   wire  splitWr  = cfg_r[CFG_WR_SPLIT];
   wire  highWrMd = cfg_r[CFG_HIGH_WR_MODE];
   // mux mode bit has no effect here: the demux port keeps its address
   wire  segEn    = cfg_r[CFG_SEG_EN];
   wire  holdMstr = cfg_r[CFG_HOLD_MASTER];
   wire  holdEn   = cfg_r[CFG_HOLD_EN];
   wire  [31:0] statusWord = {24'h000000, 2'h0, !busReqN_r, !holdAckN_r,
                               fetchExt_r, state_r};
   wire  [31:0] rdSel =
      (regAddr == REG_SYSCFG)  ? {{(32-CFG_WIDTH){1'b0}}, cfg_r} :
      (regAddr == REG_STATUS)  ? statusWord :
      (regAddr == REG_SEGMENT) ? {24'h000000, segShadow_r} :
      RDATA_UNMAPPED;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_r       <= CFG_RESET;
         segShadow_r <= 8'h00;
         regRdata_r  <= 32'h0000_0000;
      end
      else
      begin
         if (write_strobe_config)
            cfg_r <= regWdata[CFG_WIDTH-1:0];
         if (wrSeg)
            segShadow_r <= regWdata[SEG_W-1:0];
         regRdata_r <= regRead ? rdSel : 32'h0000_0000;
      end
   end

   // ==========================================
   // external fetch strap, caught after reset release
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fetchExt_r   <= 1'b0;
         strapTaken_r <= 1'b0;
      end
      else if (!strapTaken_r)
      begin
         fetchExt_r   <= !external_fetch_select;
         strapTaken_r <= 1'b1;
      end
   end

   // ==========================================
   // ready and clock out
   logic extendCycle;

   ebi_ready_sync u_ready
   (
      .clock           (clock),
      .rst_n           (rst_n),
      .readyPin        (readyPin),
      .readyEnable     (cfg_r[CFG_RDY_EN]),
      .readyActiveHigh (cfg_r[CFG_RDY_POL]),
      .extendCycle     (extendCycle)
   );

   ebi_clock_out u_system_clock_out
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .enable   (cfg_r[CFG_SYSCLK_EN]),
      .clockOut (system_clock_out)
   );

   // ==========================================
   // arbitration
   wire holdReq = holdEn && !holdMstr && !holdReqIn_n;
   wire startOk = reqValid && fetchExt_r;

   // ==========================================
   // bus cycle sequencer
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (holdReq)
               state_nxt = ST_HELD;
            else if (startOk)
            begin
               state_nxt = ST_ADDR;
               cnt_nxt   = ALE_CYCLES;
            end
         end
         ST_ADDR:
         begin
            if (cnt_r == 2'h1)
            begin
               state_nxt = ST_STROBE;
               cnt_nxt   = STROBE_CYCLES;
            end
            else
               cnt_nxt = cnt_r - 2'h1;
         end
         ST_STROBE:
         begin
            if (cnt_r == 2'h1)
               state_nxt = ST_WAIT;
            else
               cnt_nxt = cnt_r - 2'h1;
         end
         ST_WAIT:
         begin
            if (!extendCycle)
               state_nxt = ST_DONE;
         end
         ST_DONE:
            state_nxt = ST_IDLE;
         ST_HELD:
         begin
            if (!holdReq)
               state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // ==========================================
   // strobe decode
   wire strobing  = (state_nxt == ST_STROBE) || (state_nxt == ST_WAIT);
   wire nxtHeld   = (state_nxt == ST_HELD);
   wire [23:0] nxtAddr = (state_r == ST_IDLE) ? reqAddr : curAddr_r;
   wire nxtWrite  = (state_r == ST_IDLE) ? reqWrite : curWrite_r;
   wire nxtHigh   = (state_r == ST_IDLE) ? reqHighByte : curHigh_r;
   wire nxtByte   = (state_r == ST_IDLE) ? reqByte : curByte_r;
   wire nxtBus8   = (state_r == ST_IDLE) ? reqBus8 : curBus8_r;
   wire [CS_IDX_W-1:0] nxtCs = (state_r == ST_IDLE) ? reqCs : curCs_r;
   wire inCycle   = (state_nxt == ST_ADDR) || strobing;
   wire lowLane   = nxtBus8 || !nxtHigh || !nxtByte;
   wire highLane  = !nxtBus8 && (nxtHigh || !nxtByte);
   wire rdAct     = strobing && !nxtWrite;
   wire wrLowAct  = strobing && nxtWrite && (!splitWr || lowLane);
   wire wrHighAct = strobing && nxtWrite && highLane;
   wire hiEnAct   = inCycle && highLane;
   wire hiPinAct  = (splitWr && highWrMd) ? wrHighAct : hiEnAct;
   wire aleAct    = (state_nxt == ST_ADDR);
   wire [SEG_W-1:0] segNxt = segEn ? nxtAddr[23:16] : segShadow_r;

   logic [NUM_CS-1:0] csNxt;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CS; gi++)
      begin : g_cs
         assign csNxt[gi] = inCycle && (nxtCs == CS_IDX_W'(gi));
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r    <= ST_IDLE;
         cnt_r      <= 2'h0;
         curWrite_r <= 1'b0;
         curHigh_r  <= 1'b0;
         curByte_r  <= 1'b0;
         curBus8_r  <= 1'b0;
         curAddr_r  <= 24'h000000;
         curCs_r    <= '0;
      end
      else
      begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         curWrite_r <= nxtWrite;
         curHigh_r  <= nxtHigh;
         curByte_r  <= nxtByte;
         curBus8_r  <= nxtBus8;
         curAddr_r  <= nxtAddr;
         curCs_r    <= nxtCs;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdN_r       <= 1'b1;
         wrLowN_r    <= 1'b1;
         hiPinN_r    <= 1'b1;
         ale_r       <= 1'b0;
         addr_r      <= 16'h0000;
         seg_r       <= 8'h00;
         csN_r       <= '1;
         holdAckN_r  <= 1'b1;
         busReqN_r   <= 1'b1;
         done_r      <= 1'b0;
         busyOut_r   <= 1'b0;
         holdOutN_r  <= 1'b1;
         holdOutEn_r <= 1'b0;
      end
      else
      begin
         rdN_r       <= !rdAct;
         wrLowN_r    <= !wrLowAct;
         hiPinN_r    <= !hiPinAct;
         ale_r       <= aleAct;
         // address stays on the demux port in mux mode as well
         if (inCycle)
            addr_r <= nxtAddr[ADDR_W-1:0];
         seg_r       <= segNxt;
         csN_r       <= ~csNxt;
         holdAckN_r  <= !nxtHeld;
         // master asks for the bus back while held and work is pending
         busReqN_r   <= !(nxtHeld && reqValid);
         done_r      <= (state_nxt == ST_DONE);
         busyOut_r   <= (state_nxt != ST_IDLE);
         holdOutN_r  <= !(holdEn && holdMstr && reqValid);
         holdOutEn_r <= holdEn && holdMstr;
      end
   end

   // ==========================================
   // outputs
   assign rdStrobe_n              = rdN_r;
   assign low_byte_write_strobe_n = wrLowN_r;
   assign high_byte_pin_n         = hiPinN_r;
   assign addrLatchEnable         = ale_r;
   assign demux_address_port      = addr_r;
   assign segAddr                 = seg_r;
   assign chipSelect_n            = csN_r;
   assign bus_hold_ack_n          = holdAckN_r;
   assign bus_request_out_n       = busReqN_r;
   assign holdReqOut_n            = holdOutN_r;
   assign holdReqOutEn            = holdOutEn_r;
   assign reqDone                 = done_r;
   assign reqBusy                 = busyOut_r;
   assign regRdata                = regRdata_r;
   assign fetchExternal           = fetchExt_r;
endmodule : ebi_bus_ctrl

//--- inc/ebi_pkg.sv
package ebi_pkg;
   // ==========================================
   // register map
   localparam logic [3:0]  REG_SYSCFG       = 4'h0;
   localparam logic [3:0]  REG_STATUS       = 4'h4;
   localparam logic [3:0]  REG_SEGMENT      = 4'h8;
   // ==========================================
   // config field positions
   localparam int          CFG_WR_SPLIT     = 0;
   localparam int          CFG_HIGH_WR_MODE = 1;
   localparam int          CFG_RDY_EN       = 2;
   localparam int          CFG_RDY_POL      = 3;
   localparam int          CFG_MUX_MODE     = 4;
   localparam int          CFG_SEG_EN       = 5;
   localparam int          CFG_SYSCLK_EN    = 6;
   localparam int          CFG_HOLD_MASTER  = 7;
   localparam int          CFG_HOLD_EN      = 8;
   localparam int          CFG_WIDTH        = 9;
   localparam logic [8:0]  CFG_RESET        = 9'h000;
   localparam logic [31:0] RDATA_UNMAPPED   = 32'h0000_0000;
   // ==========================================
   // bus geometry and timing
   localparam int          NUM_CS           = 5;
   localparam int          CS_IDX_W         = 3;
   localparam int          ADDR_W           = 16;
   localparam int          SEG_W            = 8;
   localparam logic [1:0]  ALE_CYCLES       = 2'h1;
   localparam logic [1:0]  STROBE_CYCLES    = 2'h2;
   // ==========================================
   // bus cycle states
   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_STROBE = 3'b010,
      ST_WAIT   = 3'b011,
      ST_DONE   = 3'b100,
      ST_HELD   = 3'b101
   } ebi_state_e;
endpackage : ebi_pkg

//--- hdl/ebi_ready_sync.sv
`timescale 1ns/100ps
module ebi_ready_sync
   import ebi_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // ready pin and config
   input  wire logic readyPin,
   input  wire logic readyEnable,
   input  wire logic readyActiveHigh,
   // result
   output logic      extendCycle
);
   logic stage1_r;
   logic stage2_r;
   logic rdyAtLevel;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
      end
      else
      begin
         stage1_r <= readyPin;
         stage2_r <= stage1_r;
      end
   end

   assign rdyAtLevel  = (stage2_r == readyActiveHigh);
   assign extendCycle = readyEnable && !rdyAtLevel;
endmodule : ebi_ready_sync

//--- hdl/ebi_clock_out.sv
`timescale 1ns/100ps
module ebi_clock_out
   import ebi_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // control
   input  wire logic enable,
   // pin
   output logic      clockOut
);
   logic phase_r;

   // half-rate toggle: a flop cannot reproduce the full clock
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         phase_r <= 1'b0;
      else
         phase_r <= enable ? !phase_r : 1'b0;
   end

   assign clockOut = phase_r;
endmodule : ebi_clock_out

//--- verif/ebi_bus_ctrl_checker.sv
`timescale 1ns/100ps
module ebi_bus_ctrl_checker
   import ebi_pkg::*;
(
   // clock and reset
   input wire logic              clock,
   input wire logic              rst_n,
   // register port
   input wire logic [3:0]        regAddr,
   input wire logic [31:0]       regWdata,
   input wire logic              regWrite,
   // access request
   input wire logic              reqValid,
   input wire logic              reqWrite,
   input wire logic              reqByte,
   input wire logic              reqHighByte,
   input wire logic              reqBus8,
   input wire logic [23:0]       reqAddr,
   input wire logic              reqDone,
   // bus pins
   input wire logic              rdStrobe_n,
   input wire logic              low_byte_write_strobe_n,
   input wire logic              high_byte_pin_n,
   input wire logic              addrLatchEnable,
   input wire logic [ADDR_W-1:0] demux_address_port,
   input wire logic [SEG_W-1:0]  segAddr,
   input wire logic [NUM_CS-1:0] chipSelect_n,
   input wire logic              system_clock_out
);
   // ==========================================
   // shadow of the config register
   logic [CFG_WIDTH-1:0] cfg_r;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         cfg_r <= CFG_RESET;
      else if (regWrite && regAddr == REG_SYSCFG)
         cfg_r <= regWdata[CFG_WIDTH-1:0];
   // ==========================================
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_noOverlap;
      !rdStrobe_n |-> low_byte_write_strobe_n
         && (high_byte_pin_n || !(cfg_r[CFG_WR_SPLIT] && cfg_r[CFG_HIGH_WR_MODE]));
   endproperty
   a_noOverlap: assert property (p_noOverlap) else $error("strobes overlap");
   property p_readStrobe;
      $rose(addrLatchEnable) && !reqWrite |=> !rdStrobe_n [*2];
   endproperty
   a_readStrobe: assert property (p_readStrobe) else $error("read strobe missing");
   property p_combined;
      $rose(addrLatchEnable) && reqWrite && !cfg_r[CFG_WR_SPLIT] |=> !low_byte_write_strobe_n [*2];
   endproperty
   a_combined: assert property (p_combined) else $error("low write strobe missing");
   property p_splitHigh;
      reqValid && cfg_r[CFG_WR_SPLIT] && reqWrite && reqByte && reqHighByte && !reqBus8
         |-> low_byte_write_strobe_n;
   endproperty
   a_splitHigh: assert property (p_splitHigh) else $error("low strobe on high byte");
   property p_aleFirst;
      $fell(rdStrobe_n) |-> $past(addrLatchEnable);
   endproperty
   a_aleFirst: assert property (p_aleFirst) else $error("strobe without latch enable");
   property p_oneSelect;
      addrLatchEnable |-> $onehot(~chipSelect_n);
   endproperty
   a_oneSelect: assert property (p_oneSelect) else $error("chip select not one-hot");
   property p_address;
      addrLatchEnable && cfg_r[CFG_SEG_EN]
         |-> segAddr == reqAddr[23:16] && demux_address_port == reqAddr[15:0];
   endproperty
   a_address: assert property (p_address) else $error("address lines wrong");
   property p_noReady;
      $rose(addrLatchEnable) && !cfg_r[CFG_RDY_EN] |-> ##4 reqDone;
   endproperty
   a_noReady: assert property (p_noReady) else $error("access length wrong");
   property p_clockOut;
      cfg_r[CFG_SYSCLK_EN] && $past(cfg_r[CFG_SYSCLK_EN], 3)
         |-> system_clock_out != $past(system_clock_out);
   endproperty
   a_clockOut: assert property (p_clockOut) else $error("clock output stalled");
endmodule : ebi_bus_ctrl_checker

//--- verif/ebi_ext_party.sv
`timescale 1ns/100ps
module ebi_ext_party
(
   // clock and reset
   input wire logic       clock,
   input wire logic       rst_n,
   // strobes seen
   input wire logic       rdStrobe_n,
   input wire logic       low_byte_write_strobe_n,
   // behaviour control
   input wire logic       readyActiveHigh,
   input wire logic [3:0] waitCycles,
   input wire logic       holdWanted,
   // pins
   output logic           readyPin,
   output logic           holdReqIn_n
);
   logic [3:0] waitCnt_r;
   wire        strobeOn = !rdStrobe_n || !low_byte_write_strobe_n;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         waitCnt_r <= 4'h0;
      else if (!strobeOn)
         waitCnt_r <= 4'h0;
      else if (waitCnt_r != 4'hF)
         waitCnt_r <= waitCnt_r + 4'h1;
   // slow memory: ready stays inactive until the wait count runs out
   assign readyPin = (strobeOn && waitCnt_r >= waitCycles) ? readyActiveHigh
                                                          : !readyActiveHigh;
   assign holdReqIn_n = !holdWanted;
endmodule : ebi_ext_party

//--- verif/test_external_bus_interface.sv
`timescale 1ns/100ps
module test_external_bus_interface;
   import ebi_pkg::*;
   typedef struct packed {logic [8:0] cfg; logic [4:0] req; logic [2:0] exp;} ebi_row_s;
   logic clock, rst_n, regWrite, regRead, reqValid, reqWrite, reqFetch, reqByte;
   logic reqHighByte, reqBus8, reqDone, reqBusy, readyPin, rdStrobe_n, addrLatchEnable;
   logic low_byte_write_strobe_n, high_byte_pin_n, holdReqIn_n, holdReqOut_n, holdReqOutEn;
   logic bus_hold_ack_n, bus_request_out_n, system_clock_out, fetchExternal;
   logic readyHigh, holdWanted;
   logic [3:0]          regAddr, waitCycles;
   logic [31:0]         regWdata, regRdata, d;
   logic [23:0]         reqAddr, addr;
   logic [CS_IDX_W-1:0] reqCs;
   logic [ADDR_W-1:0]   demux_address_port;
   logic [SEG_W-1:0]    segAddr;
   logic [NUM_CS-1:0]   chipSelect_n;
   logic [2:0]          seen;
   logic [28:0]         snap;
   int                  badCount, nCompared, lat;
   // rows: config, {write fetch byte high bus8}, strobes seen {read low high}
   ebi_row_s rows [9] = '{'{9'h020, 5'h08, 3'h5}, '{9'h030, 5'h04, 3'h4},
      '{9'h020, 5'h10, 3'h3}, '{9'h020, 5'h16, 3'h3}, '{9'h023, 5'h14, 3'h2},
      '{9'h023, 5'h16, 3'h1}, '{9'h023, 5'h10, 3'h3}, '{9'h023, 5'h17, 3'h2},
      '{9'h023, 5'h00, 3'h4}};
   ebi_bus_ctrl ebi_bus_ctrl_inst (.clock, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
      .regRdata, .reqValid, .reqWrite, .reqFetch, .reqByte, .reqHighByte, .reqBus8, .reqAddr,
      .reqCs, .reqDone, .reqBusy, .external_fetch_select(1'b0), .readyPin, .rdStrobe_n,
      .low_byte_write_strobe_n, .high_byte_pin_n, .addrLatchEnable, .demux_address_port,
      .segAddr, .chipSelect_n, .holdReqIn_n, .holdReqOut_n, .holdReqOutEn, .bus_hold_ack_n,
      .bus_request_out_n, .system_clock_out, .fetchExternal);
   ebi_ext_party ebi_ext_party_inst (.clock, .rst_n, .rdStrobe_n, .low_byte_write_strobe_n,
      .readyActiveHigh(readyHigh), .waitCycles, .holdWanted, .readyPin, .holdReqIn_n);
   // ==========================================
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp)
      begin
         badCount++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic regWr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : regWr
   task automatic regRd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      v = regRdata;
   endtask : regRd
   task automatic waitDone();
      repeat (60)
      begin
         @(posedge clock);
         #1;
         lat++;
         seen |= {~rdStrobe_n, ~low_byte_write_strobe_n, ~high_byte_pin_n};
         if (addrLatchEnable)
            snap = {chipSelect_n, segAddr, demux_address_port};
         if (reqDone)
            break;
      end
      check(32'(reqDone), 32'h1);
      @(posedge clock);
      reqValid <= 1'b0;
   endtask : waitDone
   task automatic access(input logic [4:0] q, input logic [23:0] a, input logic [2:0] cs);
      @(posedge clock);
      {reqWrite, reqFetch, reqByte, reqHighByte, reqBus8} <= q;
      reqAddr <= a;
      reqCs <= cs;
      reqValid <= 1'b1;
      seen = 3'h0;
      lat = 0;
      waitDone();
   endtask : access
   task automatic endSim();
      if (badCount == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : endSim
   // ==========================================
   // stimulus
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial
   begin
      #100000;
      badCount++;
      endSim();
   end
   initial
   begin
      {rst_n, regAddr, regWdata, regWrite, regRead, reqValid, reqAddr, reqCs} = '0;
      {reqWrite, reqFetch, reqByte, reqHighByte, reqBus8, holdWanted, waitCycles} = '0;
      readyHigh = 1'b1;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      check({rdStrobe_n, low_byte_write_strobe_n, high_byte_pin_n, addrLatchEnable,
             chipSelect_n, system_clock_out, fetchExternal, reqBusy, reqDone,
             bus_hold_ack_n, bus_request_out_n, holdReqOut_n, holdReqOutEn},
            {4'hE, 5'h1F, 1'b0, 1'b1, 2'h0, 3'h7, 1'b0});
      regRd(REG_STATUS, d);
      check(32'(d[3]), 32'h1);
      regWr(4'hC, 32'hFFFF_FFFF);
      regRd(4'hC, d);
      check(d, RDATA_UNMAPPED);
      regRd(REG_SYSCFG, d);
      check(d, 32'(CFG_RESET));
      for (int i = 0; i < 9; i++)
      begin
         regWr(REG_SYSCFG, 32'(rows[i].cfg));
         addr = 24'hA51E3C + 24'(i) * 24'h010101;
         access(rows[i].req, addr, 3'(i % 5));
         check(32'(seen), 32'(rows[i].exp));
         check(32'(snap), {3'h0, ~(5'h1 << (i % 5)), addr});
      end
      regWr(REG_SYSCFG, 32'h0000_002C);
      regRd(REG_SYSCFG, d);
      check(d, 32'h0000_002C);
      waitCycles <= 4'h6;
      access(5'h04, 24'h123456, 3'h2);
      check(32'(lat > 8), 32'h1);
      regWr(REG_SYSCFG, 32'h0000_0024);
      readyHigh <= 1'b0;
      waitCycles <= 4'h0;
      access(5'h00, 24'h654321, 3'h4);
      check(32'(lat < 12), 32'h1);
      regWr(REG_SEGMENT, 32'h0000_005A);
      regWr(REG_SYSCFG, 32'h0000_0100);
      holdWanted <= 1'b1;
      repeat (3) @(posedge clock);
      reqValid <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      check({bus_hold_ack_n, bus_request_out_n, holdReqOutEn, addrLatchEnable, reqBusy},
            5'h01);
      @(posedge clock);
      holdWanted <= 1'b0;
      waitDone();
      check(32'(bus_hold_ack_n), 32'h1);
      check(32'(snap), 32'h0F5A_4321);
      regRd(REG_SEGMENT, d);
      check(d, 32'h0000_005A);
      regWr(REG_SYSCFG, 32'h0000_0180);
      reqValid <= 1'b1;
      @(posedge clock);
      #1;
      check({holdReqOut_n, holdReqOutEn}, 2'h1);
      waitDone();
      regWr(REG_SYSCFG, 32'h0000_0040);
      repeat (3) @(posedge clock);
      #1;
      seen[0] = system_clock_out;
      @(posedge clock);
      #1;
      check(32'(system_clock_out), 32'(!seen[0]));
      endSim();
   end
endmodule : test_external_bus_interface

bind ebi_bus_ctrl ebi_bus_ctrl_checker ebi_bus_ctrl_checker_inst (.clock, .rst_n, .regAddr,
   .regWdata, .regWrite, .reqValid, .reqWrite, .reqByte, .reqHighByte, .reqBus8, .reqAddr,
   .reqDone, .rdStrobe_n, .low_byte_write_strobe_n, .high_byte_pin_n, .addrLatchEnable,
   .demux_address_port, .segAddr, .chipSelect_n, .system_clock_out);
